// ---- include/rtrms_map.svh ----
// Offsets, field positions, reset values and counts for the receive message store.
// Assumes 16-bit shared memory words and 32-bit AXI4-Lite register data.
`ifndef RTRMS_MAP_SVH
`define RTRMS_MAP_SVH

// AXI4-Lite register byte addresses
`define RTRMS_REG_CTRL 8'h00
`define RTRMS_REG_DESC 8'h04
`define RTRMS_REG_STATUS 8'h08
`define RTRMS_REG_INFO 8'h0C
`define RTRMS_REG_PTR 8'h10
`define RTRMS_REG_MSGS 8'h14
`define RTRMS_CTRL_RST 2'h0
`define RTRMS_DESC_RST 16'h0000
`define RTRMS_CTRL_EN_BIT 0
`define RTRMS_CTRL_PP_BIT 1
`define RTRMS_RESP_OKAY 2'h0
`define RTRMS_RESP_SLVERR 2'h2

// Receive information word fields
`define RTRMS_INFO_CNT_MSB 15
`define RTRMS_INFO_CNT_LSB 11
`define RTRMS_INFO_CHAN_BIT 9
`define RTRMS_INFO_T2T_BIT 8
`define RTRMS_INFO_ME_BIT 7
`define RTRMS_INFO_ILL_BIT 4
`define RTRMS_INFO_TO_BIT 3
`define RTRMS_INFO_XS_BIT 2
`define RTRMS_INFO_PAR_BIT 1
`define RTRMS_INFO_MAN_BIT 0

// Descriptor control word fields and descriptor layout
`define RTRMS_IDX_MSB 15
`define RTRMS_IDX_LSB 8
`define RTRMS_INTX_BIT 7
`define RTRMS_AB_BIT 2
`define RTRMS_DESC_OFS_CTRL 16'h0000
`define RTRMS_DESC_OFS_DPA 16'h0001
`define RTRMS_DESC_OFS_DPB 16'h0002
`define RTRMS_HDR_WORDS 16'h0002
`define RTRMS_IDX_ONE 8'h01
`define RTRMS_IDX_ZERO 8'h00

`endif

// ---- include/rtrms_pkg.sv ----
// Types shared by the receive message store modules.
// Assumes the field positions of rtrms_map.svh.
package rtrms_pkg;

  // Validated receive command as seen by the store
  typedef struct packed {
    logic [4:0] rx_word_count_field;
    logic chan_a;
    logic terminal_to_terminal_flag;
    logic illegal;
  } rtrms_cmd_t;

  // One received data word with its line errors
  typedef struct packed {
    logic [15:0] data;
    logic par_err;
    logic man_err;
  } rtrms_word_t;

  // Message end with count errors
  typedef struct packed {
    logic too_few;
    logic excess;
  } rtrms_end_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RD_CTRL, ST_RD_PTR, ST_COLLECT, ST_WR_DATA,
    ST_WR_INFO, ST_WR_TT, ST_WR_CTRL, ST_WR_PTR
  } rtrms_state_t;

endpackage : rtrms_pkg

// ---- rtl/rtrms_info_pack.sv ----
// Assembles the receive information word from command and error flags.
// Pure combinational; the caller registers the inputs.
`timescale 1ns/1ns
`include "rtrms_map.svh"
module rtrms_info_pack (
  input wire rtrms_pkg::rtrms_cmd_t cmd,
  input wire logic too_few_words_flag,
  input wire logic excess_word_flag,
  input wire logic word_parity_error_flag,
  input wire logic biphase_code_error_flag,
  output logic [15:0] info
);
  import rtrms_pkg::*;

  logic message_error_flag;

  // Any cause raises the summary error bit
  assign message_error_flag = cmd.illegal | too_few_words_flag | excess_word_flag
    | word_parity_error_flag | biphase_code_error_flag;

  // Field placement, unused bits zero
  always_comb begin
    info = 16'h0000;
    info[`RTRMS_INFO_CNT_MSB:`RTRMS_INFO_CNT_LSB] = cmd.rx_word_count_field;
    info[`RTRMS_INFO_CHAN_BIT] = cmd.chan_a;
    info[`RTRMS_INFO_T2T_BIT] = cmd.terminal_to_terminal_flag;
    info[`RTRMS_INFO_ME_BIT] = message_error_flag;
    info[`RTRMS_INFO_ILL_BIT] = cmd.illegal;
    info[`RTRMS_INFO_TO_BIT] = too_few_words_flag;
    info[`RTRMS_INFO_XS_BIT] = excess_word_flag;
    info[`RTRMS_INFO_PAR_BIT] = word_parity_error_flag;
    info[`RTRMS_INFO_MAN_BIT] = biphase_code_error_flag;
  end

endmodule : rtrms_info_pack

// ---- rtl/rtrms_axil_regs.sv ----
// AXI4-Lite slave holding control registers and showing store status.
// Assumes one outstanding write and one outstanding read per master.
`timescale 1ns/1ns
`include "rtrms_map.svh"
module rtrms_axil_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] ctrl,
  output logic [15:0] desc_base,
  input wire logic [15:0] stat_status,
  input wire logic [15:0] stat_info,
  input wire logic [15:0] stat_ptr,
  input wire logic [15:0] stat_msgs
);
  import rtrms_pkg::*;

  logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt, ctrl_r, ctrl_nxt;
  logic [15:0] desc_r, desc_nxt;

  // Handshake outputs
  assign s_axi_awready = !aw_r && !b_r;
  assign s_axi_wready = !w_r && !b_r;
  assign s_axi_arready = !r_r;
  assign s_axi_bvalid = b_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = r_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign ctrl = ctrl_r;
  assign desc_base = desc_r;

  // Write and read channel next state
  always_comb begin
    aw_nxt = aw_r;
    w_nxt = w_r;
    b_nxt = b_r;
    r_nxt = r_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bresp_nxt = bresp_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    desc_nxt = desc_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_r && w_r) begin
      aw_nxt = 1'b0;
      w_nxt = 1'b0;
      b_nxt = 1'b1;
      bresp_nxt = `RTRMS_RESP_OKAY;
      unique case (awaddr_r)
        `RTRMS_REG_CTRL: if (wstrb_r[0]) ctrl_nxt = wdata_r[1:0];
        `RTRMS_REG_DESC: begin
          if (wstrb_r[0]) desc_nxt[7:0] = wdata_r[7:0];
          if (wstrb_r[1]) desc_nxt[15:8] = wdata_r[15:8];
        end
        `RTRMS_REG_STATUS, `RTRMS_REG_INFO, `RTRMS_REG_PTR, `RTRMS_REG_MSGS: ;
        default: bresp_nxt = `RTRMS_RESP_SLVERR;
      endcase
    end
    if (b_r && s_axi_bready) b_nxt = 1'b0;
    if (r_r && s_axi_rready) r_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt = 1'b1;
      rresp_nxt = `RTRMS_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        `RTRMS_REG_CTRL: rdata_nxt[1:0] = ctrl_r;
        `RTRMS_REG_DESC: rdata_nxt[15:0] = desc_r;
        `RTRMS_REG_STATUS: rdata_nxt[15:0] = stat_status;
        `RTRMS_REG_INFO: rdata_nxt[15:0] = stat_info;
        `RTRMS_REG_PTR: rdata_nxt[15:0] = stat_ptr;
        `RTRMS_REG_MSGS: rdata_nxt[15:0] = stat_msgs;
        default: rresp_nxt = `RTRMS_RESP_SLVERR;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      b_r <= 1'b0;
      r_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
      ctrl_r <= `RTRMS_CTRL_RST;
      desc_r <= `RTRMS_DESC_RST;
    end else begin
      aw_r <= aw_nxt;
      w_r <= w_nxt;
      b_r <= b_nxt;
      r_r <= r_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bresp_r <= bresp_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      desc_r <= desc_nxt;
    end
  end

endmodule : rtrms_axil_regs

// ---- rtl/rtrms_rx_store.sv ----
// Receive message store: writes info word, time tag and data of each
// receive message into shared memory and maintains the descriptor index.
// Assumes a decoder offering commands, words and message end by valid/ready
// and a 16-bit memory port that answers each request with one ack.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
`include "rtrms_map.svh"
module rtrms_rx_store (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_valid,
  input wire rtrms_pkg::rtrms_cmd_t cmd,
  input wire logic [15:0] time_tag,
  output logic cmd_ready,
  input wire logic word_valid,
  input wire rtrms_pkg::rtrms_word_t word,
  output logic word_ready,
  input wire logic end_valid,
  input wire rtrms_pkg::rtrms_end_t end_info,
  output logic end_ready,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_ack,
  output logic index_zero_event
);
  import rtrms_pkg::*;

  rtrms_state_t state_r, state_nxt;
  rtrms_cmd_t cmd_r, cmd_nxt;
  logic [15:0] tt_r, tt_nxt, cw_r, cw_nxt, bptr_r, bptr_nxt, cnt_r, cnt_nxt;
  logic [15:0] wd_r, wd_nxt, info_r, info_nxt, msgs_r, msgs_nxt;
  logic par_r, par_nxt, man_r, man_nxt, to_r, to_nxt, xs_r, xs_nxt;
  logic evt_r, evt_nxt;
  logic [1:0] ctrl;
  logic [15:0] desc_base, info_w;
  logic [7:0] idx;
  logic pingpong, enable, me, advance;

  assign enable = ctrl[`RTRMS_CTRL_EN_BIT];
  assign pingpong = ctrl[`RTRMS_CTRL_PP_BIT];
  assign idx = cw_r[`RTRMS_IDX_MSB:`RTRMS_IDX_LSB];
  assign me = info_w[`RTRMS_INFO_ME_BIT];
  // Pointer advances only for clean index-mode messages with index left
  assign advance = !pingpong && !me && (idx != `RTRMS_IDX_ZERO);

  // Register slave
  rtrms_axil_regs u_regs (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .ctrl(ctrl), .desc_base(desc_base),
    .stat_status({idx, 7'h00, (state_r != ST_IDLE)}),
    .stat_info(info_r), .stat_ptr(cnt_r), .stat_msgs(msgs_r)
  );

  // Info word from held command and accumulated errors
  rtrms_info_pack u_info (
    .cmd(cmd_r),
    .too_few_words_flag(to_r),
    .excess_word_flag(xs_r),
    .word_parity_error_flag(par_r),
    .biphase_code_error_flag(man_r),
    .info(info_w)
  );

  // Decoder handshakes
  assign cmd_ready = enable && (state_r == ST_IDLE);
  assign word_ready = (state_r == ST_COLLECT);
  assign end_ready = (state_r == ST_COLLECT) && !word_valid; // Pending word goes first
  assign index_zero_event = evt_r;

  // Memory request decode
  always_comb begin
    mem_req = 1'b1;
    mem_we = 1'b1;
    mem_addr = 16'h0000;
    mem_wdata = 16'h0000;
    unique case (state_r)
      ST_RD_CTRL: begin
        mem_we = 1'b0;
        mem_addr = desc_base + `RTRMS_DESC_OFS_CTRL;
      end
      ST_RD_PTR: begin
        mem_we = 1'b0;
        mem_addr = desc_base + ((pingpong && !cw_r[`RTRMS_AB_BIT]) ?
          `RTRMS_DESC_OFS_DPB : `RTRMS_DESC_OFS_DPA);
      end
      ST_WR_DATA: begin
        mem_addr = cnt_r;
        mem_wdata = wd_r;
      end
      ST_WR_INFO: begin
        mem_addr = bptr_r;
        mem_wdata = info_w;
      end
      ST_WR_TT: begin
        mem_addr = bptr_r + 16'h0001;
        mem_wdata = tt_r;
      end
      ST_WR_CTRL: begin
        mem_addr = desc_base + `RTRMS_DESC_OFS_CTRL;
        mem_wdata = {idx - `RTRMS_IDX_ONE, cw_r[`RTRMS_IDX_LSB-1:0]};
      end
      ST_WR_PTR: begin
        mem_addr = desc_base + `RTRMS_DESC_OFS_DPA;
        mem_wdata = cnt_r;
      end
      default: begin
        mem_req = 1'b0;
        mem_we = 1'b0;
      end
    endcase
  end

  // Message sequence next state
  always_comb begin
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    tt_nxt = tt_r;
    cw_nxt = cw_r;
    bptr_nxt = bptr_r;
    cnt_nxt = cnt_r;
    wd_nxt = wd_r;
    info_nxt = info_r;
    msgs_nxt = msgs_r;
    par_nxt = par_r;
    man_nxt = man_r;
    to_nxt = to_r;
    xs_nxt = xs_r;
    evt_nxt = 1'b0;
    unique case (state_r)
      ST_IDLE: if (cmd_valid && cmd_ready) begin
        cmd_nxt = cmd;
        tt_nxt = time_tag;
        {par_nxt, man_nxt, to_nxt, xs_nxt} = 4'h0;
        state_nxt = ST_RD_CTRL;
      end
      ST_RD_CTRL: if (mem_ack) begin
        cw_nxt = mem_rdata;
        state_nxt = ST_RD_PTR;
      end
      ST_RD_PTR: if (mem_ack) begin
        bptr_nxt = mem_rdata;
        cnt_nxt = mem_rdata + `RTRMS_HDR_WORDS;
        state_nxt = ST_COLLECT;
      end
      ST_COLLECT: begin
        if (word_valid) begin
          wd_nxt = word.data;
          par_nxt = par_r | word.par_err;
          man_nxt = man_r | word.man_err;
          state_nxt = ST_WR_DATA;
        end else if (end_valid) begin
          to_nxt = end_info.too_few;
          xs_nxt = end_info.excess;
          state_nxt = ST_WR_INFO;
        end
      end
      ST_WR_DATA: if (mem_ack) begin
        cnt_nxt = cnt_r + 16'h0001;
        state_nxt = ST_COLLECT;
      end
      ST_WR_INFO: if (mem_ack) begin
        info_nxt = info_w;
        state_nxt = ST_WR_TT;
      end
      ST_WR_TT: if (mem_ack) begin
        msgs_nxt = msgs_r + 16'h0001;
        state_nxt = advance ? ST_WR_CTRL : ST_IDLE;
      end
      ST_WR_CTRL: if (mem_ack) begin
        evt_nxt = (idx == `RTRMS_IDX_ONE) && cw_r[`RTRMS_INTX_BIT];
        state_nxt = ST_WR_PTR;
      end
      ST_WR_PTR: if (mem_ack) state_nxt = ST_IDLE;
    endcase
  end

  // Register stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      cmd_r <= '0;
      tt_r <= 16'h0000;
      cw_r <= 16'h0000;
      bptr_r <= 16'h0000;
      cnt_r <= 16'h0000;
      wd_r <= 16'h0000;
      info_r <= 16'h0000;
      msgs_r <= 16'h0000;
      par_r <= 1'b0;
      man_r <= 1'b0;
      to_r <= 1'b0;
      xs_r <= 1'b0;
      evt_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      tt_r <= tt_nxt;
      cw_r <= cw_nxt;
      bptr_r <= bptr_nxt;
      cnt_r <= cnt_nxt;
      wd_r <= wd_nxt;
      info_r <= info_nxt;
      msgs_r <= msgs_nxt;
      par_r <= par_nxt;
      man_r <= man_nxt;
      to_r <= to_nxt;
      xs_r <= xs_nxt;
      evt_r <= evt_nxt;
    end
  end

  // Checks on the store sequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_tt_capture;
    cmd_valid && cmd_ready |=> state_r == ST_RD_CTRL && tt_r == $past(time_tag);
  endproperty
  a_tt_capture: assert property (p_tt_capture) else $error("time tag not captured");

  property p_info_after_end;
    end_valid && end_ready |=> mem_req && mem_we && mem_addr == bptr_r;
  endproperty
  a_info_after_end: assert property (p_info_after_end) else $error("info not next");

  property p_tt_second;
    state_r == ST_WR_INFO && mem_ack |=> mem_we && mem_addr == bptr_r + 16'h0001
      && mem_wdata == tt_r;
  endproperty
  a_tt_second: assert property (p_tt_second) else $error("time tag not second");

  property p_data_offset;
    state_r == ST_WR_DATA |-> 16'(mem_addr - bptr_r) >= `RTRMS_HDR_WORDS;
  endproperty
  a_data_offset: assert property (p_data_offset) else $error("data below header");

  property p_me_summary;
    state_r == ST_WR_INFO |-> mem_wdata[7] == (|mem_wdata[4:0]);
  endproperty
  a_me_summary: assert property (p_me_summary) else $error("error summary wrong");

  property p_unused_zero;
    state_r == ST_WR_INFO |-> mem_wdata[10] == 1'b0 && mem_wdata[6:5] == 2'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_no_dec_on_error;
    state_r == ST_WR_CTRL |-> !me && !cmd_r.illegal && idx != 8'h00;
  endproperty
  a_no_dec_on_error: assert property (p_no_dec_on_error) else $error("bad decrement");

  property p_pingpong_no_ptr;
    pingpong && state_r == ST_WR_TT |=> state_r != ST_WR_CTRL && state_r != ST_WR_PTR;
  endproperty
  a_pingpong_no_ptr: assert property (p_pingpong_no_ptr) else $error("pointer written");

  property p_event_cause;
    index_zero_event |-> $past(state_r) == ST_WR_CTRL && $past(idx) == 8'h01
      && $past(cw_r[7]);
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("stray index event");

  property p_ptr_value;
    state_r == ST_WR_PTR |-> mem_wdata == cnt_r && cnt_r - bptr_r >= 16'h0002;
  endproperty
  a_ptr_value: assert property (p_ptr_value) else $error("pointer value wrong");

endmodule : rtrms_rx_store

// ---- tb/rtrms_mem_model.sv ----
// Behavioural shared memory on the store's request/ack port.
// Assumes a level request held until ack; the bench sets the stall depth.
`timescale 1ns/1ns
module rtrms_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata,
  output logic mem_ack,
  input wire logic [2:0] stall
);
  logic [15:0] mem [0:65535];
  logic [2:0] wait_r;
  logic [15:0] junk_r;
  // Stall, then one ack pulse; writes land on the ack edge
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 3'h0;
      mem_ack <= 1'b0;
      junk_r <= 16'hA5A5;
    end else begin
      junk_r <= ~junk_r;
      mem_ack <= 1'b0;
      if (mem_req && !mem_ack) begin
        wait_r <= (wait_r >= stall) ? 3'h0 : wait_r + 3'h1;
        mem_ack <= (wait_r >= stall);
      end
      if (mem_req && mem_ack && mem_we) begin
        mem[mem_addr] <= mem_wdata;
      end
    end
  end
  // Read data only valid with ack, toggling garbage otherwise
  assign mem_rdata = mem_ack ? mem[mem_addr] : junk_r;
endmodule : rtrms_mem_model

// ---- tb/rt_receive_message_store_tb.sv ----
// Self-checking bench for the receive message store.
// Assumes the memory model above and the store's AXI4-Lite map.
`timescale 1ns/1ns
module rt_receive_message_store_tb;
  import rtrms_pkg::*;
  logic clk = 1'b0, resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cmd_valid = 1'b0, word_valid = 1'b0, end_valid = 1'b0;
  rtrms_cmd_t cmd = '0;
  rtrms_word_t word = '0;
  rtrms_end_t end_info = '0;
  logic [15:0] time_tag = 16'h0, mem_addr, mem_wdata, mem_rdata;
  logic cmd_ready, word_ready, end_ready, mem_req, mem_we, mem_ack, index_zero_event;
  logic [2:0] stall = 3'h0;
  logic [31:0] seed = 32'h27580DFA;
  logic [15:0] ptr_e;
  logic pp = 1'b0;
  logic [7:0] ctl_e = 8'h80;
  int error_cnt = 0, samples_checked = 0, cyc = 0, ev_cnt = 0, ev_exp = 0, idx_e;

  rtrms_rx_store dut_u (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd,
    .time_tag, .cmd_ready, .word_valid, .word, .word_ready, .end_valid, .end_info,
    .end_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
    .index_zero_event);
  rtrms_mem_model mem_u (.clk, .resetn, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack, .stall);

  // Clock, event counting and hang guard
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (index_zero_event === 1'b1) ev_cnt <= ev_cnt + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected information word from command and error flags
  function automatic logic [15:0] exp_info(rtrms_cmd_t c, logic tf, ex, pe, me);
    return {c.rx_word_count_field, 1'b0, c.chan_a, c.terminal_to_terminal_flag,
      |{c.illegal, tf, ex, pe, me}, 2'b00, c.illegal, tf, ex, pe, me};
  endfunction : exp_info

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // Wait for ready i (0 cmd, 1 word, 2 end) and pass the taking edge
  task automatic wait_rdy(input int i);
    logic [2:0] r;
    do begin
      @(negedge clk);
      r = {end_ready, word_ready, cmd_ready};
    end while (r[i] !== 1'b1);
    @(posedge clk);
  endtask : wait_rdy

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (ta === 1'b1) s_axi_awvalid <= 1'b0;
      if (tw === 1'b1) s_axi_wvalid <= 1'b0;
    end while (tb !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    logic ta, tv;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_arready;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ta === 1'b1) s_axi_arvalid <= 1'b0;
    end while (tv !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : axi_rd

  // One message from the decoder side, then storage and descriptor checks
  task automatic run_msg(input rtrms_cmd_t c, input int nw, input logic tf, ex, pe, me);
    logic [15:0] dw [0:39];
    logic [15:0] tt, base, ie;
    logic err;
    base = pp ? 16'h0200 : ptr_e;
    err = |{c.illegal, tf, ex, pe, me};
    tt = 16'(rnd());
    stall <= 3'(rnd() % 4);
    cmd <= c;
    time_tag <= tt;
    cmd_valid <= 1'b1;
    wait_rdy(0);
    cmd_valid <= 1'b0;
    time_tag <= ~tt;
    for (int k = 0; k < nw; k++) begin
      dw[k] = 16'(rnd());
      word <= '{data: dw[k], par_err: pe && k == 0, man_err: me && k == nw - 1};
      word_valid <= 1'b1;
      wait_rdy(1);
    end
    word_valid <= 1'b0;
    end_info <= '{too_few: tf, excess: ex};
    end_valid <= 1'b1;
    wait_rdy(2);
    end_valid <= 1'b0;
    wait_rdy(0);
    ie = exp_info(c, tf, ex, pe, me);
    chk("info", mem_u.mem[base], ie);
    chk("info command", mem_u.mem[base][15:8], ie[15:8]);
    chk("info errors", mem_u.mem[base][4:0], ie[4:0]);
    chk("time tag", mem_u.mem[base + 16'h1], tt);
    // Data of errored messages is not relied upon
    for (int k = 0; k < nw; k++) begin
      if (!err) chk("data", mem_u.mem[base + 16'(k) + 16'h2], dw[k]);
    end
    if (!pp && !err && idx_e != 0) begin
      idx_e--;
      ptr_e = base + 16'h2 + 16'(nw);
      if (idx_e == 0 && ctl_e[7]) ev_exp++;
    end
    chk("ctrl word", mem_u.mem[16'h0040], {8'(idx_e), ctl_e});
    chk("pointer A", mem_u.mem[16'h0041], ptr_e);
    chk("events", ev_cnt, ev_exp);
  endtask : run_msg

  // Main sequence
  initial begin
    logic [1:0] rsp;
    logic [31:0] rd;
    rtrms_cmd_t c;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    axi_rd(8'h00, rd, rsp);
    chk("ctrl reset", rd, 32'h0);
    axi_wr(8'h20, 32'h1, rsp);
    chk("bad write", rsp, 2'h2);
    axi_rd(8'h20, rd, rsp);
    chk("bad read", rsp, 2'h2);
    mem_u.mem[16'h0040] = 16'h0280;
    mem_u.mem[16'h0041] = 16'h0100;
    mem_u.mem[16'h0042] = 16'h0200;
    idx_e = 2;
    ptr_e = 16'h0100;
    axi_wr(8'h04, 32'h40, rsp);
    axi_wr(8'h00, 32'h1, rsp);
    axi_rd(8'h04, rd, rsp);
    chk("desc", rd, 32'h40);
    // Index walk of three, two, three words; pointer then frozen
    for (int i = 0; i < 3; i++) begin
      c = '{rx_word_count_field: (i == 1) ? 5'h2 : 5'h3, chan_a: i[0],
        terminal_to_terminal_flag: ~i[0], illegal: 1'b0};
      run_msg(c, c.rx_word_count_field, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    // One error of each kind with a live index, then clean random messages
    mem_u.mem[16'h0040] = 16'h0380;
    idx_e = 3;
    for (int k = 0; k < 9; k++) begin
      c = '{rx_word_count_field: 5'(rnd() % 8 + 1), chan_a: 1'(rnd()),
        terminal_to_terminal_flag: 1'(rnd()), illegal: k == 0};
      run_msg(c, c.rx_word_count_field + (k == 2) - (k == 1), k == 1, k == 2, k == 3, k == 4);
    end
    // Ping-pong mode with a live index: second pointer, no descriptor update
    axi_wr(8'h00, 32'h3, rsp);
    mem_u.mem[16'h0040] = 16'h0280;
    idx_e = 2;
    pp = 1'b1;
    run_msg(c, c.rx_word_count_field, 1'b0, 1'b0, 1'b0, 1'b0);
    // Index mode with the event disabled: one to zero raises nothing
    axi_wr(8'h00, 32'h1, rsp);
    mem_u.mem[16'h0040] = 16'h0100;
    idx_e = 1;
    ctl_e = 8'h00;
    pp = 1'b0;
    run_msg(c, c.rx_word_count_field, 1'b0, 1'b0, 1'b0, 1'b0);
    axi_rd(8'h14, rd, rsp);
    chk("msgs", rd, 32'h0000_000E);
    end_sim();
  end
endmodule : rt_receive_message_store_tb
